// [fdc_pkg.sv]
// Shared constants and types for the frequency and duty counter
package fdc_pkg;
	localparam int CNT_W = 24;
	localparam int IDX_W = 8;
	localparam int ADDR_W = 10;
	localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS2 = 8'h27;
	localparam logic [IDX_W-1:0] IDX_PWR2 = 8'h5c;
	localparam logic [IDX_W-1:0] IDX_GATE_U = 8'h65;
	localparam logic [IDX_W-1:0] IDX_GATE_M = 8'h66;
	localparam logic [IDX_W-1:0] IDX_GATE_L = 8'h67;
	localparam logic [IDX_W-1:0] IDX_CYC_U = 8'h68;
	localparam logic [IDX_W-1:0] IDX_CYC_M = 8'h69;
	localparam logic [IDX_W-1:0] IDX_CYC_L = 8'h6a;
	localparam logic [IDX_W-1:0] IDX_HI_U = 8'h6b;
	localparam logic [IDX_W-1:0] IDX_HI_M = 8'h6c;
	localparam logic [IDX_W-1:0] IDX_HI_L = 8'h6d;
	localparam logic [IDX_W-1:0] IDX_STATUS = 8'h6e;
	localparam logic [IDX_W-1:0] IDX_PORT3 = 8'h70;
	// Field positions
	localparam int DONE_BIT = 1;
	localparam int SRC_BIT = 4;
	localparam int EN_BIT = 3;
	localparam int STA_PIN_BIT = 7;
	localparam int STA_CMP_BIT = 6;
	localparam int STA_OVF_BIT = 0;
	localparam int P3_COMPARATOR_OUTPUT_EN_BIT = 7;
	localparam int P3_DIR_BIT = 6;
	// Reset values
	localparam logic [7:0] PWR2_RST = 8'h00;
	localparam logic [7:0] PORT3_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Gray-coded measurement states
	typedef enum logic [2:0] {
		FDC_IDLE = 3'b000,
		FDC_ARMED = 3'b001,
		FDC_RUN = 3'b011,
		FDC_TAIL = 3'b010,
		FDC_DONE = 3'b110
	} fdc_state_t;
endpackage

// [fdc_reg_if.sv]
// Register access carrier between the bus slave and the counter core
`timescale 1ns/1ps
interface fdc_reg_if;
	logic wr_en;
	logic [7:0] wr_idx;
	logic [7:0] wr_data;
	logic wr_hit;
	logic rd_en;
	logic [7:0] rd_idx;
	logic [7:0] rd_data;
	logic rd_hit;
	modport slave (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input wr_hit, rd_data, rd_hit);
	modport core (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output wr_hit, rd_data, rd_hit);
endinterface

// [fdc_sync.sv]
// Two-stage synchroniser for the pin-level inputs
`timescale 1ns/1ps
module fdc_sync
	import fdc_pkg::*;
#(
	parameter int W = 2
)(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} fdc_sync_st_t;
	fdc_sync_st_t q;
	fdc_sync_st_t d;
	always_comb
	begin
		d.s1 = async_i;
		d.s2 = q.s1;
	end
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			q <= '0;
		else if (ce_i)
			q <= d;
	end
	assign sync_o = q.s2;
endmodule // fdc_sync

// [fdc_axil.sv]
// AXI4-Lite slave front end feeding the register carrier
`timescale 1ns/1ps
module fdc_axil
	import fdc_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic [ADDR_W-1:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [ADDR_W-1:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	fdc_reg_if.slave bus
);
	typedef struct packed {
		logic awv;
		logic wv;
		logic [IDX_W-1:0] widx;
		logic [7:0] wdat;
		logic wlane;
		logic awrdy;
		logic wrdy;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [7:0] rdat;
		logic [1:0] rresp;
	} fdc_axil_st_t;
	fdc_axil_st_t q;
	fdc_axil_st_t d;
	logic both;
	logic rd_take;
	always_comb
	begin
		d = q;
		both = q.awv & q.wv;
		rd_take = ce_i & arvalid_i & q.arrdy;
		bus.wr_en = ce_i & both & q.wlane;
		bus.wr_idx = q.widx;
		bus.wr_data = q.wdat;
		bus.rd_en = rd_take;
		bus.rd_idx = araddr_i[ADDR_W-1:2];
		if (awvalid_i && q.awrdy)
		begin
			d.awv = 1'b1;
			d.widx = awaddr_i[ADDR_W-1:2];
		end
		if (wvalid_i && q.wrdy)
		begin
			d.wv = 1'b1;
			d.wdat = wdata_i[7:0];
			d.wlane = wstrb_i[0];
		end
		if (q.bvalid && bready_i)
			d.bvalid = 1'b0;
		if (both)
		begin
			d.awv = 1'b0;
			d.wv = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = bus.wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (q.rvalid && rready_i)
			d.rvalid = 1'b0;
		if (rd_take)
		begin
			d.rvalid = 1'b1;
			d.rdat = bus.rd_data;
			d.rresp = bus.rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		d.awrdy = ~d.awv & ~d.bvalid;
		d.wrdy = ~d.wv & ~d.bvalid;
		d.arrdy = ~d.rvalid;
	end
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			q <= '0;
		else if (ce_i)
			q <= d;
	end
	assign awready_o = q.awrdy;
	assign wready_o = q.wrdy;
	assign bvalid_o = q.bvalid;
	assign bresp_o = q.bresp;
	assign arready_o = q.arrdy;
	assign rvalid_o = q.rvalid;
	assign rdata_o = {24'h000000, q.rdat};
	assign rresp_o = q.rresp;
endmodule // fdc_axil

// [fdc_top.sv]
// Frequency and duty-cycle counter with its register file
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
// Operation
// - Source select 0 picks comparator output, 1 picks external count pin.
// - Three 24-bit counters: gate timer, cycle counter, high-time counter.
// - Gate and high-time count system clocks; cycle counter counts input periods.
// - High-time counter advances only in clocks where the input is high.
// - Gate timer low byte held at zero while counting is disabled.
// - Gate bits 23:8 writable only when disabled; otherwise change only by counting.
// - After enabling, counting starts at the first input rising edge.
// - After gate overflow, counting stops at the next input rising edge.
// - An interrupt request is raised when the counters stop.
// - Completion shows as bit 1 of the second interrupt flag register.
// - Cycle counter then holds whole input periods seen while counting.
// - High-time counter then holds clocks the input spent high.
// - Cycle-count overflow bit set whenever the cycle counter overflows.
// - Overflow bit cleared by reading status or while disabled.
// - Status bit 7 shows live external pin level regardless of selection.
// - Port 3 bits 7 and 6 both set drive comparator output onto port 3 pin 7.
module fdc_top
	import fdc_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic comparator_output_i,
	input wire logic external_count_pin_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic measure_irq_o,
	output logic port3_pin7_o,
	output logic port3_pin7_oe_o
);
	// ==========================================================
	// State
	typedef struct packed {
		fdc_state_t st;
		logic prev;
		logic [CNT_W-1:0] gate;
		logic [CNT_W-1:0] cyc;
		logic [CNT_W-1:0] hi;
		logic ovf;
		logic done;
		logic [7:0] pwr;
		logic [7:0] port3;
		logic pin7;
		logic pin7_oe;
	} fdc_core_st_t;
	fdc_core_st_t q;
	fdc_core_st_t d;
	fdc_reg_if bus ();
	logic [1:0] pins_s;
	logic cmp_s;
	logic ext_s;
	logic sel;
	logic en;
	logic rise;
	logic running;

	// Counter step with carry out
	function automatic logic [CNT_W:0] inc24(input logic [CNT_W-1:0] v);
		inc24 = {1'b0, v} + {{CNT_W{1'b0}}, 1'b1};
	endfunction

	function automatic logic idx_known(input logic [IDX_W-1:0] idx);
		idx_known = (idx == IDX_IRQ_FLAGS2) || (idx == IDX_PWR2) || (idx == IDX_PORT3)
			|| ((idx >= IDX_GATE_U) && (idx <= IDX_STATUS));
	endfunction

	// ==========================================================
	// Submodules
	fdc_sync #(.W(2)) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.async_i({comparator_output_i, external_count_pin_i}),
		.sync_o(pins_s)
	);

	fdc_axil u_axil (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.awaddr_i(s_axi_awaddr_i),
		.awvalid_i(s_axi_awvalid_i),
		.awready_o(s_axi_awready_o),
		.wdata_i(s_axi_wdata_i),
		.wstrb_i(s_axi_wstrb_i),
		.wvalid_i(s_axi_wvalid_i),
		.wready_o(s_axi_wready_o),
		.bresp_o(s_axi_bresp_o),
		.bvalid_o(s_axi_bvalid_o),
		.bready_i(s_axi_bready_i),
		.araddr_i(s_axi_araddr_i),
		.arvalid_i(s_axi_arvalid_i),
		.arready_o(s_axi_arready_o),
		.rdata_o(s_axi_rdata_o),
		.rresp_o(s_axi_rresp_o),
		.rvalid_o(s_axi_rvalid_o),
		.rready_i(s_axi_rready_i),
		.bus(bus.slave)
	);

	assign cmp_s = pins_s[1];
	assign ext_s = pins_s[0];
	assign sel = q.pwr[SRC_BIT] ? ext_s : cmp_s;
	assign en = q.pwr[EN_BIT];
	assign rise = sel & ~q.prev;
	assign running = (q.st == FDC_RUN) || (q.st == FDC_TAIL);

	// ==========================================================
	// Read mux
	always_comb
	begin
		bus.rd_hit = idx_known(bus.rd_idx);
		bus.wr_hit = idx_known(bus.wr_idx);
		unique case (bus.rd_idx)
			IDX_IRQ_FLAGS2: bus.rd_data = {6'h00, q.done, 1'b0};
			IDX_PWR2: bus.rd_data = q.pwr;
			IDX_GATE_U: bus.rd_data = q.gate[23:16];
			IDX_GATE_M: bus.rd_data = q.gate[15:8];
			IDX_GATE_L: bus.rd_data = q.gate[7:0];
			IDX_CYC_U: bus.rd_data = q.cyc[23:16];
			IDX_CYC_M: bus.rd_data = q.cyc[15:8];
			IDX_CYC_L: bus.rd_data = q.cyc[7:0];
			IDX_HI_U: bus.rd_data = q.hi[23:16];
			IDX_HI_M: bus.rd_data = q.hi[15:8];
			IDX_HI_L: bus.rd_data = q.hi[7:0];
			IDX_STATUS: bus.rd_data = {ext_s, cmp_s, 5'h00, q.ovf};
			IDX_PORT3: bus.rd_data = q.port3;
			default: bus.rd_data = BYTE_ZERO;
		endcase
	end

	// ==========================================================
	// Next state
	always_comb
	begin
		logic [CNT_W:0] cyc_n;
		logic [CNT_W:0] gate_n;
		logic [CNT_W:0] hi_n;
		cyc_n = inc24(q.cyc);
		gate_n = inc24(q.gate);
		hi_n = inc24(q.hi);
		d = q;
		d.prev = sel;
		// Software side first so that hardware events win
		if (bus.rd_en && bus.rd_idx == IDX_STATUS)
			d.ovf = 1'b0;
		if (bus.wr_en)
		begin
			unique case (bus.wr_idx)
				IDX_IRQ_FLAGS2:
				begin
					if (bus.wr_data[DONE_BIT])
						d.done = 1'b0;
				end
				IDX_PWR2: d.pwr = bus.wr_data;
				IDX_GATE_U:
				begin
					if (!en)
						d.gate[23:16] = bus.wr_data;
				end
				IDX_GATE_M:
				begin
					if (!en)
						d.gate[15:8] = bus.wr_data;
				end
				IDX_PORT3: d.port3 = bus.wr_data;
				default: d.port3 = q.port3;
			endcase
		end
		if (!en)
		begin
			d.st = FDC_IDLE;
			d.gate[7:0] = BYTE_ZERO;
			d.cyc = CNT_ZERO;
			d.hi = CNT_ZERO;
			d.ovf = 1'b0;
		end
		else
		begin
			unique case (q.st)
				FDC_IDLE: d.st = FDC_ARMED;
				FDC_ARMED:
				begin
					if (rise)
						d.st = FDC_RUN;
				end
				FDC_RUN, FDC_TAIL:
				begin
					d.gate = gate_n[CNT_W-1:0];
					if (sel)
						d.hi = hi_n[CNT_W-1:0];
					if (rise)
					begin
						d.cyc = cyc_n[CNT_W-1:0];
						if (cyc_n[CNT_W])
							d.ovf = 1'b1;
					end
					if (q.st == FDC_RUN && q.gate == CNT_MAX)
						d.st = FDC_TAIL;
					if (q.st == FDC_TAIL && rise)
					begin
						d.st = FDC_DONE;
						d.done = 1'b1;
					end
				end
				FDC_DONE: d.st = FDC_DONE;
			endcase
		end
		d.pin7 = cmp_s;
		d.pin7_oe = q.port3[P3_COMPARATOR_OUTPUT_EN_BIT] & q.port3[P3_DIR_BIT];
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			q <= '0;
			q.pwr <= PWR2_RST;
			q.port3 <= PORT3_RST;
		end
		else if (ce_i)
			q <= d;
	end

	assign measure_irq_o = q.done;
	assign port3_pin7_o = q.pin7;
	assign port3_pin7_oe_o = q.pin7_oe;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_start_edge;
		ce_i && en && q.st == FDC_ARMED && rise |=> q.st == FDC_RUN;
	endproperty
	a_start_edge: assert property (p_start_edge) else $error("no start at first edge");

	property p_no_early_start;
		ce_i && en && q.st == FDC_ARMED && !rise |=> q.st == FDC_ARMED && $stable(q.gate);
	endproperty
	a_no_early_start: assert property (p_no_early_start) else $error("counting before edge");

	property p_low_zero;
		ce_i && !en |=> q.gate[7:0] == BYTE_ZERO && q.cyc == CNT_ZERO && q.hi == CNT_ZERO;
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("counters not cleared");

	property p_upper_locked;
		ce_i && en && (q.st == FDC_ARMED || q.st == FDC_DONE) |=> $stable(q.gate[23:8]);
	endproperty
	a_upper_locked: assert property (p_upper_locked) else $error("gate upper changed");

	property p_high_only;
		ce_i && en && running && !sel |=> $stable(q.hi);
	endproperty
	a_high_only: assert property (p_high_only) else $error("high count while low");

	property p_gate_wrap;
		ce_i && en && q.st == FDC_RUN && q.gate == CNT_MAX |=> q.st == FDC_TAIL && q.gate == CNT_ZERO;
	endproperty
	a_gate_wrap: assert property (p_gate_wrap) else $error("gate overflow missed");

	property p_stop_irq;
		ce_i && en && q.st == FDC_TAIL && rise |=> q.st == FDC_DONE && measure_irq_o;
	endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("no stop or irq");

	property p_ovf_set;
		ce_i && en && running && rise && q.cyc == CNT_MAX |=> q.ovf && q.cyc == CNT_ZERO;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow bit not set");

	property p_ovf_clear;
		ce_i && !en |=> !q.ovf;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow bit kept");

	property p_frozen;
		ce_i && en && q.st == FDC_DONE ##1 ce_i && en |=> $stable(q.cyc) && $stable(q.hi) && $stable(q.gate);
	endproperty
	a_frozen: assert property (p_frozen) else $error("result moved after stop");

	property p_done_hold;
		ce_i && q.done && !(bus.wr_en && bus.wr_idx == IDX_IRQ_FLAGS2 && bus.wr_data[DONE_BIT]) |=> q.done;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("done flag lost");

	property p_cyc_step;
		ce_i && en && running && rise |=> q.cyc == $past(q.cyc) + 24'h000001;
	endproperty
	a_cyc_step: assert property (p_cyc_step) else $error("cycle count missed an edge");

	property p_hi_step;
		ce_i && en && running && sel |=> q.hi == $past(q.hi) + 24'h000001;
	endproperty
	a_hi_step: assert property (p_hi_step) else $error("high count missed a clock");

	property p_gate_step;
		ce_i && en && q.st == FDC_RUN |=> q.gate == $past(q.gate) + 24'h000001;
	endproperty
	a_gate_step: assert property (p_gate_step) else $error("gate missed a clock");

	property p_armed_clear;
		ce_i && en && q.st == FDC_ARMED |=> q.cyc == CNT_ZERO && q.hi == CNT_ZERO;
	endproperty
	a_armed_clear: assert property (p_armed_clear) else $error("counted before start edge");

	property p_oe_on;
		ce_i && q.port3[P3_COMPARATOR_OUTPUT_EN_BIT] && q.port3[P3_DIR_BIT] |=> port3_pin7_oe_o;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("pin 7 not driven");

	c_done: cover property (ce_i && q.st == FDC_TAIL ##1 q.st == FDC_DONE);
	c_ovf: cover property (ce_i && !q.ovf ##1 q.ovf);
	c_gate_wr: cover property (bus.wr_en && bus.wr_idx == IDX_GATE_U && !en);
	c_pin7: cover property (port3_pin7_oe_o);
endmodule // fdc_top

// [fdc_wave_src.sv]
// Square-wave source standing in for the comparator output or the count pin
`timescale 1ns/1ps
module fdc_wave_src
(
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic idle_lvl_i,
	input wire logic [7:0] hi_len_i,
	input wire logic [7:0] lo_len_i,
	output logic wave_o
);
	// ==========================================
	// Wave generator
	logic [7:0] cnt_q;
	// Lengths are loaded at each toggle, so a change only takes effect at the next phase
	always_ff @(posedge clk_i)
	begin
		if (!run_i)
		begin
			wave_o <= idle_lvl_i;
			cnt_q <= lo_len_i;
		end
		else if (cnt_q <= 8'h01)
		begin
			wave_o <= ~wave_o;
			cnt_q <= wave_o ? lo_len_i : hi_len_i;
		end
		else
		begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule // fdc_wave_src

// [tb.sv]
// Self-checking bench for the frequency and duty counter
`timescale 1ns/1ps
module tb
	import fdc_pkg::*;
;
	logic clk_i, sys_rst_i, ce_i, cmp_run, pin_run, cmp_idle, pin_idle, cmp_w, pin_w;
	logic [7:0] cmp_hi, cmp_lo, pin_hi, pin_lo;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid, irq, p7, p7oe;
	logic [31:0] wdata, rdata, last_data, r;
	logic [1:0] bresp, rresp, last_resp;
	logic [3:0] wstrb;
	int fail_count, n_compared, cycles;

	fdc_top u_fdc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .comparator_output_i(cmp_w),
		.external_count_pin_i(pin_w), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1),
		.measure_irq_o(irq), .port3_pin7_o(p7), .port3_pin7_oe_o(p7oe));
	fdc_wave_src u_fdc_wave_src_cmp (.clk_i(clk_i), .run_i(cmp_run), .idle_lvl_i(cmp_idle),
		.hi_len_i(cmp_hi), .lo_len_i(cmp_lo), .wave_o(cmp_w));
	fdc_wave_src u_fdc_wave_src_pin (.clk_i(clk_i), .run_i(pin_run), .idle_lvl_i(pin_idle),
		.hi_len_i(pin_hi), .lo_len_i(pin_lo), .wave_o(pin_w));

	// ==========================================
	// Clock and watchdog
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			fail_count++;
			print_verdict;
		end
	end

	// ==========================================
	// Shared tasks
	task automatic print_verdict;
		if (fail_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		last_resp = bresp;
	endtask
	task automatic rd(input logic [7:0] idx);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		last_resp = rresp;
		last_data = rdata;
	endtask
	task automatic rd24(input logic [7:0] idx, output logic [23:0] v);
		rd(idx);
		v[23:16] = last_data[7:0];
		rd(idx + 8'h01);
		v[15:8] = last_data[7:0];
		rd(idx + 8'h02);
		v[7:0] = last_data[7:0];
	endtask
	// Gate starts 256 clocks short of overflow, then runs on to the next input edge
	function automatic logic [31:0] exp_periods(input int p);
		return 32'((32'h1000000 - 32'hffff00) / p + 1);
	endfunction

	// ==========================================
	// One measurement; the unselected source gets a different wave
	task automatic meas(input logic src, input logic [7:0] hi, input logic [7:0] lo);
		logic [23:0] g, c, h, c2;
		logic [31:0] k;
		int w;
		{cmp_hi, cmp_lo, pin_hi, pin_lo} <= src ? {lo + 8'd3, hi + 8'd5, hi, lo} : {hi, lo, lo + 8'd3, hi + 8'd5};
		cmp_run <= 1'b1;
		pin_run <= 1'b1;
		wr(IDX_PWR2, {3'b000, src, 4'h0});
		wr(IDX_GATE_U, 8'hff);
		wr(IDX_GATE_M, 8'hff);
		rd(IDX_GATE_L);
		chk("gate_low_idle", last_data, 32'h0);
		wr(IDX_PWR2, {3'b000, src, 4'h8});
		w = 0;
		while (irq !== 1'b1 && w < 1000)
		begin
			@(posedge clk_i);
			w++;
		end
		chk("irq_done", {31'h0, irq}, 32'h1);
		wr(IDX_GATE_U, 8'h12);
		rd(IDX_IRQ_FLAGS2);
		chk("done_flag", last_data, 32'h2);
		rd24(IDX_GATE_U, g);
		rd24(IDX_CYC_U, c);
		rd24(IDX_HI_U, h);
		k = exp_periods(int'(hi) + int'(lo));
		chk("cycle_count", {8'h00, c}, k);
		chk("gate_span", {8'h00, g} + 32'h100, k * (hi + lo));
		chk("high_time", {8'h00, h}, k * hi);
		rd24(IDX_CYC_U, c2);
		chk("cycle_frozen", {8'h00, c2}, {8'h00, c});
		rd(IDX_STATUS);
		chk("ovf_after_run", last_data & 32'h01, 32'h0);
		wr(IDX_IRQ_FLAGS2, 8'h02);
		@(posedge clk_i);
		chk("irq_cleared", {31'h0, irq}, 32'h0);
		wr(IDX_PWR2, {3'b000, src, 4'h0});
		rd24(IDX_CYC_U, c2);
		chk("cycle_cleared", {8'h00, c2}, 32'h0);
		cmp_run <= 1'b0;
		pin_run <= 1'b0;
		@(posedge clk_i);
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		{sys_rst_i, ce_i, awvalid, wvalid, arvalid} = 5'b11000;
		{cmp_run, pin_run, cmp_idle, pin_idle} = 4'h0;
		{cmp_hi, cmp_lo, pin_hi, pin_lo} = 32'h02020202;
		{awaddr, araddr, wdata, cycles, fail_count, n_compared} = '0;
		wstrb = 4'h1;
		void'($urandom(32'hed0796ff));
		repeat (10) @(posedge clk_i);
		chk("idle_in_reset", {26'h0, awready, wready, arready, bvalid, rvalid, irq}, 32'h0);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("ready_after_reset", {29'h0, awready, wready, arready}, 32'h7);
		rd(IDX_PWR2);
		chk("pwr2_reset", last_data, {24'h0, PWR2_RST});
		rd(IDX_IRQ_FLAGS2);
		chk("irq_flags_reset", last_data, 32'h0);
		rd(IDX_PORT3);
		chk("port3_reset", last_data, {24'h0, PORT3_RST});
		wstrb <= 4'h0;
		wr(IDX_PORT3, 8'hc0);
		wstrb <= 4'h1;
		rd(IDX_PORT3);
		chk("port3_no_strobe", last_data, {24'h0, PORT3_RST});
		rd(8'h01);
		chk("unmapped_rresp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
		wr(8'h01, 8'h5a);
		chk("unmapped_bresp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
		wr(IDX_PORT3, 8'hc0);
		@(posedge clk_i);
		chk("pin7_oe_on", {31'h0, p7oe}, 32'h1);
		wr(IDX_PORT3, 8'h80);
		@(posedge clk_i);
		chk("pin7_oe_off", {31'h0, p7oe}, 32'h0);
		meas(1'b0, 8'd2, 8'd2);
		meas(1'b1, 8'd100, 8'd60);
		repeat (4)
		begin
			r = $urandom;
			meas(r[0], 8'd2 + 8'(r[8:4]), 8'd2 + 8'(r[15:11]));
		end
		repeat (4) @(posedge clk_i);
		for (int i = 0; i < 2; i++)
		begin
			pin_idle <= i[0];
			cmp_idle <= ~i[0];
			ce_i <= 1'b0;
			repeat (4) @(posedge clk_i);
			chk("pin7_frozen", {31'h0, p7}, {31'h0, i[0]});
			ce_i <= 1'b1;
			repeat (4) @(posedge clk_i);
			chk("pin7_level", {31'h0, p7}, {31'h0, ~i[0]});
			rd(IDX_STATUS);
			chk("status_pin", last_data, {24'h0, i[0], ~i[0], 6'h00});
		end
		print_verdict;
	end
endmodule // tb
